// ---- rtl/pmw_seq.sv ----
// Page-mode DRAM wait-state sequencer
`timescale 1ns/1ps
`include "pmw_params.svh"

module pmw_seq
	import pmw_pkg::*;
(
	input wire logic mclk,
	input wire logic nrst,
	input wire logic cyc_start,
	input wire logic cyc_write,
	input wire logic [`PMW_BANK_W-1:0] cyc_bank,
	input wire logic [`PMW_ROW_W-1:0] cyc_row,
	input wire logic cyc_ems,
	input wire logic cache_hit,
	input wire logic other_cyc,
	input wire logic cfg_pipe,
	input wire logic cfg_xpre,
	input wire logic [`PMW_ADD_W-1:0] cfg_add_ws,
	input wire logic cfg_cache,
	input wire logic cfg_banks_equal,
	output logic cyc_ready,
	output logic busy,
	output logic ras_prech_q,
	output pmw_class_e class_q,
	output logic [`PMW_CNT_W-1:0] ws_q
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	pmw_cls_if cif ();
	pmw_state_e state_q;
	pmw_state_e state_d;
	logic [`PMW_ROW_W-1:0] open_row_q [`PMW_BANKS];
	logic [`PMW_BANKS-1:0] open_vld_q;
	logic first_q;
	logic last_wr_q;
	logic [`PMW_CNT_W-1:0] cnt_q;
	logic [`PMW_CNT_W-1:0] total;
	logic [`PMW_CNT_W-1:0] prech_len;
	logic go_direct;
	logic start_ok;
	logic dram_cyc;
	pmw_class_e cls;

	// ----------------------------------------------------------------
	// Classification
	// ----------------------------------------------------------------
	// Page compare for one bank
	function automatic logic row_match(input logic vld, input logic [`PMW_ROW_W-1:0] a,
		input logic [`PMW_ROW_W-1:0] b);
		return vld && (a == b);
	endfunction : row_match

	// Classify the incoming cycle
	always_comb begin
		cls = PMW_MISS;
		if (cfg_cache && !cyc_write && cache_hit) begin
			cls = PMW_CACHE;
		end else if (first_q && cfg_banks_equal && !cyc_ems) begin
			cls = PMW_FIRST;
		end else if (row_match(open_vld_q[cyc_bank], open_row_q[cyc_bank], cyc_row)) begin
			cls = PMW_HIT;
		// unequal banks or EMS fall to miss
		end else begin
			cls = PMW_MISS;
		end
	end

	// Feed the wait-state table
	assign cif.cls = cls;
	assign cif.write = cyc_write;
	assign cif.pipe = cfg_pipe;
	assign cif.xpre = cfg_xpre;
	assign cif.cache_on = cfg_cache;
	assign cif.raw = last_wr_q;

	pmw_ws_table u_table (
		.t(cif.tab)
	);

	// ----------------------------------------------------------------
	// Wait-state total
	// ----------------------------------------------------------------
	// table count plus configured extra waits
	assign total = {1'b0, cif.ws} + {2'b00, cfg_add_ws};

	// Precharge phase length on a miss
	assign prech_len = cfg_xpre ? (`PMW_PRECHG_CYC + `PMW_XPRECHG_CYC) : `PMW_PRECHG_CYC;

	// Cycle accepted only while idle
	assign start_ok = cyc_start && (state_q == PMW_IDLE);
	assign go_direct = start_ok && (total == `PMW_RST_CNT);
	assign dram_cyc = start_ok && (cls != PMW_CACHE);

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	// Next state
	always_comb begin
		state_d = state_q;
		case (state_q)
			PMW_IDLE: begin
				if (start_ok && !go_direct) begin
					state_d = (cls == PMW_MISS) ? PMW_PRECH : PMW_WAIT;
				end
			end
			PMW_PRECH: begin
				if (cnt_q == `PMW_CNT_W'(1)) begin
					state_d = PMW_IDLE;
				end else if (ws_q - cnt_q + `PMW_CNT_W'(1) >= prech_len) begin
					state_d = PMW_WAIT;
				end
			end
			PMW_WAIT: begin
				if (cnt_q == `PMW_CNT_W'(1)) begin
					state_d = PMW_IDLE;
				end
			end
			default: state_d = PMW_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			state_q <= PMW_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// Wait countdown
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			cnt_q <= `PMW_RST_CNT;
		end else if (start_ok) begin
			cnt_q <= total;
		end else if (cnt_q != `PMW_RST_CNT) begin
			cnt_q <= cnt_q - `PMW_CNT_W'(1);
		end
	end

	// Captured class and wait count of the current cycle
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			class_q <= PMW_HIT;
			ws_q <= `PMW_RST_CNT;
		end else if (start_ok) begin
			class_q <= cls;
			ws_q <= total;
		end
	end

	// precharge only on a true miss
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			ras_prech_q <= 1'b0;
		end else begin
			ras_prech_q <= (state_d == PMW_PRECH);
		end
	end

	// Ready at the last wait, or at once with no wait
	assign cyc_ready = go_direct || ((state_q != PMW_IDLE) && (cnt_q == `PMW_CNT_W'(1)));
	assign busy = (state_q != PMW_IDLE);

	// ----------------------------------------------------------------
	// Page tracking
	// ----------------------------------------------------------------
	// open rows, one per bank
	generate
		for (genvar b = 0; b < `PMW_BANKS; b++) begin : g_bank
			always_ff @(posedge mclk) begin
				if (!nrst) begin
					open_row_q[b] <= `PMW_RST_ROW;
					open_vld_q[b] <= 1'b0;
				end else if (other_cyc) begin
					open_vld_q[b] <= 1'b0;
				end else if (dram_cyc && (cyc_bank == `PMW_BANK_W'(b))) begin
					open_row_q[b] <= cyc_row;
					open_vld_q[b] <= 1'b1;
				end
			end
		end
	endgenerate

	// other master leaves all RAS high
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			first_q <= 1'b0;
		end else if (other_cyc) begin
			first_q <= 1'b1;
		end else if (dram_cyc) begin
			first_q <= 1'b0;
		end
	end

	// remember a write for read after write
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			last_wr_q <= 1'b0;
		end else if (other_cyc) begin
			last_wr_q <= 1'b0;
		end else if (start_ok) begin
			last_wr_q <= cyc_write;
		end
	end

endmodule : pmw_seq

// ---- rtl/pmw_params.svh ----
// Constants for page-mode wait-state sequencing
`ifndef PMW_PARAMS_SVH
`define PMW_PARAMS_SVH

// ----------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------
`define PMW_BANKS 4
`define PMW_BANK_W 2
`define PMW_ROW_W 12
`define PMW_WS_W 3
`define PMW_ADD_W 2
`define PMW_CNT_W 4

// ----------------------------------------------------------------
// Wait-state counts, in processor clocks
// ----------------------------------------------------------------
`define PMW_WS_0 3'h0
`define PMW_WS_1 3'h1
`define PMW_WS_2 3'h2
`define PMW_WS_3 3'h3
`define PMW_WS_4 3'h4
`define PMW_WS_5 3'h5

// ----------------------------------------------------------------
// RAS precharge length on a page miss, in processor clocks
// ----------------------------------------------------------------
`define PMW_PRECHG_CYC 4'h2
`define PMW_XPRECHG_CYC 4'h1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PMW_RST_ROW 12'h000
`define PMW_RST_CNT 4'h0
`define PMW_RST_WS 3'h0

`endif

// ---- rtl/pmw_pkg.sv ----
// Types for page-mode wait-state sequencing
package pmw_pkg;

	// Cycle class as seen by the page comparator
	typedef enum logic [1:0] {
		PMW_HIT,
		PMW_FIRST,
		PMW_MISS,
		PMW_CACHE
	} pmw_class_e;

	// Sequencer states
	typedef enum logic [1:0] {
		PMW_IDLE,
		PMW_PRECH,
		PMW_WAIT
	} pmw_state_e;

endpackage : pmw_pkg

// ---- rtl/pmw_cls_if.sv ----
// Carrier between the sequencer and the wait-state table
`timescale 1ns/1ps
interface pmw_cls_if;
	import pmw_pkg::*;
	pmw_class_e cls;
	logic write;
	logic pipe;
	logic xpre;
	logic cache_on;
	logic raw;
	logic [2:0] ws;

	modport seq (output cls, output write, output pipe, output xpre, output cache_on,
		output raw, input ws);
	modport tab (input cls, input write, input pipe, input xpre, input cache_on,
		input raw, output ws);
endinterface : pmw_cls_if

// ---- rtl/pmw_ws_table.sv ----
// Wait-state table for page-mode DRAM cycles
`timescale 1ns/1ps
`include "pmw_params.svh"
module pmw_ws_table
	import pmw_pkg::*;
(
	pmw_cls_if.tab t
);

	// ----------------------------------------------------------------
	// Lookup
	// ----------------------------------------------------------------
	function automatic logic [2:0] ws_lookup(input pmw_class_e c, input logic wr,
		input logic pp, input logic xp, input logic co, input logic rw);
		logic [2:0] r;
		r = `PMW_WS_0;
		if (co) begin
			// Discrete cache present
			case (c)
				PMW_CACHE: r = `PMW_WS_0;
				PMW_HIT: r = wr ? `PMW_WS_0 : `PMW_WS_1;
				PMW_FIRST: r = wr ? `PMW_WS_1 : `PMW_WS_3;
				PMW_MISS: r = wr ? (xp ? `PMW_WS_3 : `PMW_WS_2) : (xp ? `PMW_WS_5 : `PMW_WS_4);
				default: r = `PMW_WS_0;
			endcase
		end else if (wr) begin
			case (c)
				PMW_HIT: r = pp ? `PMW_WS_0 : `PMW_WS_1;
				PMW_FIRST: r = pp ? `PMW_WS_1 : `PMW_WS_2;
				PMW_MISS: r = pp ? (xp ? `PMW_WS_3 : `PMW_WS_2) : (xp ? `PMW_WS_4 : `PMW_WS_3);
				default: r = `PMW_WS_0;
			endcase
		end else begin
			case (c)
				// read page hit, read after write
				PMW_HIT: r = pp ? (rw ? `PMW_WS_1 : `PMW_WS_0) : `PMW_WS_1;
				PMW_FIRST: r = pp ? `PMW_WS_2 : `PMW_WS_3;
				PMW_MISS: r = pp ? (xp ? `PMW_WS_4 : `PMW_WS_3) : (xp ? `PMW_WS_5 : `PMW_WS_4);
				default: r = `PMW_WS_0;
			endcase
		end
		return r;
	endfunction : ws_lookup

	// Table output
	assign t.ws = ws_lookup(t.cls, t.write, t.pipe, t.xpre, t.cache_on, t.raw);

endmodule : pmw_ws_table

// ---- verif/pmw_seq_checker.sv ----
// Concurrent checks on the sequencer ports
`timescale 1ns/1ps
module pmw_seq_checker
	import pmw_pkg::*;
(
	input wire logic mclk,
	input wire logic nrst,
	input wire logic cyc_start,
	input wire logic cyc_write,
	input wire logic cyc_ems,
	input wire logic cache_hit,
	input wire logic cfg_pipe,
	input wire logic cfg_xpre,
	input wire logic [1:0] cfg_add_ws,
	input wire logic cfg_cache,
	input wire logic cfg_banks_equal,
	input wire logic cyc_ready,
	input wire logic busy,
	input wire logic ras_prech_q,
	input wire pmw_class_e class_q,
	input wire logic [3:0] ws_q
);
	logic [3:0] cnt_q;
	logic tk_q;
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	// Cycle counter from the taking edge
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			cnt_q <= 4'h0;
			tk_q <= 1'b0;
		end else begin
			cnt_q <= (cyc_start && !busy) ? 4'h1 : cnt_q + 4'h1;
			tk_q <= cyc_start && !busy;
		end
	end
	a_ready_count: assert property (busy |-> cyc_ready == (cnt_q == ws_q))
		else $error("ready at wrong count");
	a_hit_wait: assert property (tk_q && class_q == PMW_HIT && !$past(cfg_cache)
		&& $past(cyc_write || !cfg_pipe) |-> ws_q == !$past(cfg_pipe) + $past(cfg_add_ws))
		else $error("hit wait wrong");
	a_first_wait: assert property (tk_q && class_q == PMW_FIRST && !$past(cfg_cache)
		|-> ws_q == 4'h1 + !$past(cfg_pipe) + !$past(cyc_write) + $past(cfg_add_ws))
		else $error("first wait wrong");
	a_miss_wait: assert property (tk_q && class_q == PMW_MISS && !$past(cfg_cache)
		|-> ws_q == 4'h2 + !$past(cfg_pipe) + !$past(cyc_write) + $past(cfg_xpre)
		+ $past(cfg_add_ws)) else $error("miss wait wrong");
	a_cache_hit: assert property (tk_q && $past(cfg_cache && cache_hit && !cyc_write)
		|-> class_q == PMW_CACHE && ws_q == $past(cfg_add_ws)) else $error("cache hit wrong");
	a_cache_miss: assert property (tk_q && $past(cfg_cache && !cyc_write)
		&& class_q != PMW_CACHE |-> ws_q == $past(cfg_add_ws) + (class_q == PMW_HIT ? 4'h1
		: class_q == PMW_FIRST ? 4'h3 : 4'h4 + $past(cfg_xpre))) else $error("cache miss wrong");
	a_first_gate: assert property (tk_q && $past(cyc_ems || !cfg_banks_equal)
		|-> class_q != PMW_FIRST) else $error("shortcut on ems");
	// precharge two clocks, three with extra
	a_prech_len: assert property (tk_q && class_q == PMW_MISS |-> ras_prech_q
		##1 ras_prech_q ##1 (ras_prech_q == $past(cfg_xpre, 3)))
		else $error("precharge span wrong");
	a_prech_none: assert property (tk_q && class_q != PMW_MISS |-> !ras_prech_q)
		else $error("precharge off miss");
	c_first: cover property (tk_q && class_q == PMW_FIRST);
	c_cache: cover property (tk_q && class_q == PMW_CACHE);
	c_long: cover property (cyc_ready && ws_q >= 4'h5);
endmodule : pmw_seq_checker

bind pmw_seq pmw_seq_checker u_chk (.*);

// ---- verif/pmw_host_model.sv ----
// Host bus model that offers page-mode cycles
`timescale 1ns/1ps
module pmw_host_model (
	input wire logic mclk,
	input wire logic busy,
	output logic cyc_start,
	output logic cyc_write,
	output logic [1:0] cyc_bank,
	output logic [11:0] cyc_row,
	output logic cyc_ems,
	output logic cache_hit,
	output logic other_cyc
);
	initial begin
		{cyc_start, cyc_write, cyc_bank, cyc_row, cyc_ems, cache_hit, other_cyc} = '0;
	end
	// Hold a request until taken, then scramble released lines
	task automatic issue(input logic w, input logic [1:0] b, input logic [11:0] r,
		input logic e, input logic h);
		@(posedge mclk);
		{cyc_start, cyc_write, cyc_bank, cyc_row, cyc_ems, cache_hit} <= {1'b1, w, b, r, e, h};
		do @(posedge mclk); while (busy);
		{cyc_start, cyc_write, cyc_bank, cyc_row, cyc_ems, cache_hit} <= {1'b0, ~w, ~b, ~r, ~e, ~h};
	endtask : issue
	// One refresh pulse while idle, all rows closed
	task automatic refresh;
		do @(posedge mclk); while (busy);
		other_cyc <= 1'b1;
		@(posedge mclk);
		other_cyc <= 1'b0;
	endtask : refresh
endmodule : pmw_host_model

// ---- verif/test_pmw_seq.sv ----
// Self-checking bench for the page-mode wait-state sequencer
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
	$display("BAD %0t got %h exp %h", $time, g, e); end end
module test_pmw_seq
	import pmw_pkg::*;
;
	logic mclk = 0, nrst = 0, cfg_pipe = 0, cfg_xpre = 0, cfg_cache = 0, cfg_banks_equal = 1;
	logic [1:0] cfg_add_ws = '0;
	logic cyc_start, cyc_write, cyc_ems, cache_hit, other_cyc, cyc_ready, busy, ras_prech_q;
	logic [1:0] cyc_bank;
	logic [11:0] cyc_row;
	logic [3:0] ws_q;
	pmw_class_e class_q;
	logic [5:0] exp_q[$];
	int error_cnt = 0, samples_checked = 0;
	always #10 mclk = ~mclk;
	pmw_host_model host (.mclk(mclk), .busy(busy), .cyc_start(cyc_start), .cyc_write(cyc_write),
		.cyc_bank(cyc_bank), .cyc_row(cyc_row), .cyc_ems(cyc_ems), .cache_hit(cache_hit),
		.other_cyc(other_cyc));
	pmw_seq dut (.mclk(mclk), .nrst(nrst), .cyc_start(cyc_start), .cyc_write(cyc_write),
		.cyc_bank(cyc_bank), .cyc_row(cyc_row), .cyc_ems(cyc_ems), .cache_hit(cache_hit),
		.other_cyc(other_cyc), .cfg_pipe(cfg_pipe), .cfg_xpre(cfg_xpre), .cfg_add_ws(cfg_add_ws),
		.cfg_cache(cfg_cache), .cfg_banks_equal(cfg_banks_equal), .cyc_ready(cyc_ready),
		.busy(busy), .ras_prech_q(ras_prech_q), .class_q(class_q), .ws_q(ws_q));
	// Note expected class and waits, then offer the cycle
	task automatic run(input logic w, input logic [1:0] b, input logic [11:0] r,
		input logic e, input logic h, input pmw_class_e c, input logic [3:0] n);
		exp_q.push_back({c, n + {2'h0, cfg_add_ws}});
		host.issue(w, b, r, e, h);
	endtask : run
	task automatic results;
		$display("errors %0d checks %0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : results
	// Compare each finished cycle with the oldest note
	always @(posedge mclk) if (cyc_ready && nrst) begin
		#1;
		`CHK({class_q, ws_q}, exp_q.pop_front())
	end
	// Watchdog
	initial begin
		repeat (5000) @(posedge mclk);
		error_cnt++;
		results();
	end
	initial begin
		logic [11:0] r;
		logic [1:0] b;
		logic p, x;
		void'($urandom(32'h2fb0));
		repeat (6) @(posedge mclk);
		nrst <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			while (exp_q.size() != 0) @(posedge mclk);
			{p, x} = i[1:0];
			cfg_pipe <= i == 4 ? '1 : p;
			cfg_xpre <= i == 4 ? '0 : x;
			cfg_cache <= i == 4;
			cfg_add_ws <= 2'($urandom);
			r = 12'($urandom);
			b = 2'($urandom);
			@(posedge mclk);
			host.refresh();
			if (i == 4) begin
				run('0, b, r, '0, '1, PMW_CACHE, 4'h0);
				host.refresh();
				run('0, b, r, '0, '0, PMW_FIRST, 4'h3);
				run('0, b, r, '0, '0, PMW_HIT, 4'h1);
				run('1, b, r ^ 12'h1, '0, '0, PMW_MISS, 4'h2);
				run('0, b, r ^ 12'h2, '0, '0, PMW_MISS, 4'h4);
				run('1, b, r ^ 12'h2, '0, '0, PMW_HIT, 4'h0);
			end else begin
				run('0, b, r, '0, '0, PMW_FIRST, 4'h2 + !p);
				run('1, b, r, '0, '0, PMW_HIT, {3'h0, !p});
				run('0, b, r, '0, '0, PMW_HIT, 4'h1);
				run('0, b, r, '0, '0, PMW_HIT, {3'h0, !p});
				run('1, b, r ^ 12'h1, '0, '0, PMW_MISS, 4'h2 + !p + x);
				run('0, b, r ^ 12'h2, '0, '0, PMW_MISS, 4'h3 + !p + x);
				run('1, b ^ 2'h1, r, '0, '0, PMW_MISS, 4'h2 + !p + x);
				run('1, b, r ^ 12'h2, '0, '0, PMW_HIT, {3'h0, !p});
				host.refresh();
				run('1, b, r, '1, '0, PMW_MISS, 4'h2 + !p + x);
				cfg_banks_equal <= 1'b0;
				host.refresh();
				run('1, b, r, '0, '0, PMW_MISS, 4'h2 + !p + x);
				cfg_banks_equal <= 1'b1;
				host.refresh();
				run('1, b, r, '0, '0, PMW_FIRST, 4'h1 + !p);
			end
		end
		repeat (12) @(posedge mclk);
		`CHK(exp_q.size(), 0)
		results();
	end
endmodule : test_pmw_seq
